// ### hdl/psrc_pkg.sv
// constants for the peripheral soft reset control block
package psrc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned DATA_W       = 32;
  localparam logic [11:0] OFS_CTRL_A   = 12'h040;
  localparam logic [11:0] OFS_CTRL_B   = 12'h044;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // implemented bits: all other positions are read-only zero
  // ----------------------------------------------------------------
  localparam logic [31:0] IMPL_MASK_A  = 32'h0100_0048;
  localparam logic [31:0] IMPL_MASK_B  = 32'h030f_5037;

  // ----------------------------------------------------------------
  // field positions, first control register
  // ----------------------------------------------------------------
  localparam int unsigned BIT_CAN_UNIT_ZERO_RESET     = 24;
  localparam int unsigned BIT_PWRDN    = 6;
  localparam int unsigned BIT_WDOG     = 3;

  // ----------------------------------------------------------------
  // field positions, second control register
  // ----------------------------------------------------------------
  localparam int unsigned BIT_CMP1     = 25;
  localparam int unsigned BIT_CMP0     = 24;
  localparam int unsigned BIT_GPC3     = 19;
  localparam int unsigned BIT_GPC2     = 18;
  localparam int unsigned BIT_GPC1     = 17;
  localparam int unsigned BIT_GPC0     = 16;
  localparam int unsigned BIT_TW1      = 14;
  localparam int unsigned BIT_TW0      = 12;
  localparam int unsigned BIT_SS1      = 5;
  localparam int unsigned BIT_SS0      = 4;
  localparam int unsigned BIT_AS2      = 2;
  localparam int unsigned BIT_AS1      = 1;
  localparam int unsigned BIT_AS0      = 0;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

endpackage

// ### hdl/psrc_top.sv
// soft reset control registers with an axi4-lite slave and per-unit reset outputs
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps

// Contract
// - writes to control a only change bits that capability mask a allows
// - writes to control b only change bits that capability mask b allows
// - control a bit 24 is read/write reset for can unit zero
// - control a bit 6 is read/write reset for the power-down unit
// - control a bit 3 is read/write reset for the watchdog unit
// - control b bits 25 and 24 reset comparators one and zero
// - control b bits 19 to 16 reset general counters three to zero
// - control b bit 14 resets two-wire unit one
// - control b bit 12 resets two-wire unit zero
// - control b bits 5 and 4 reset sync serial units one and zero
// - control b bits 2, 1, 0 reset async serial units two, one, zero
// - both control registers are zero after system reset
// - unimplemented bits are read-only zero; software writes back what it read
module psrc_top
  import psrc_pkg::*;
(
  // clock and reset
  input  wire logic                        CLK_IN,
  input  wire logic                        RESET_N_IN,
  // axi4-lite write address and data
  input  wire logic [psrc_pkg::ADDR_W-1:0] S_AXI_AWADDR_IN,
  input  wire logic                        S_AXI_AWVALID_IN,
  output logic                             S_AXI_AWREADY_OUT,
  input  wire logic [psrc_pkg::DATA_W-1:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]                  S_AXI_WSTRB_IN,
  input  wire logic                        S_AXI_WVALID_IN,
  output logic                             S_AXI_WREADY_OUT,
  // axi4-lite write response
  output logic [1:0]                       S_AXI_BRESP_OUT,
  output logic                             S_AXI_BVALID_OUT,
  input  wire logic                        S_AXI_BREADY_IN,
  // axi4-lite read
  input  wire logic [psrc_pkg::ADDR_W-1:0] S_AXI_ARADDR_IN,
  input  wire logic                        S_AXI_ARVALID_IN,
  output logic                             S_AXI_ARREADY_OUT,
  output logic [psrc_pkg::DATA_W-1:0]      S_AXI_RDATA_OUT,
  output logic [1:0]                       S_AXI_RRESP_OUT,
  output logic                             S_AXI_RVALID_OUT,
  input  wire logic                        S_AXI_RREADY_IN,
  // device capability masks, one bit per present unit
  input  wire logic [psrc_pkg::DATA_W-1:0] CAPABILITY_MASK_A_IN,
  input  wire logic [psrc_pkg::DATA_W-1:0] CAPABILITY_MASK_B_IN,
  // unit resets, active high
  output logic                             CAN_UNIT_ZERO_RESET_OUT,
  output logic                             POWER_DOWN_UNIT_RESET_OUT,
  output logic                             WATCHDOG_UNIT_RESET_OUT,
  output logic                             COMPARATOR_UNIT_ZERO_RESET_OUT,
  output logic                             COMPARATOR_UNIT_ONE_RESET_OUT,
  output logic                             GP_COUNTER_ZERO_RESET_OUT,
  output logic                             GP_COUNTER_ONE_RESET_OUT,
  output logic                             GP_COUNTER_TWO_RESET_OUT,
  output logic                             GP_COUNTER_THREE_RESET_OUT,
  output logic                             TWO_WIRE_UNIT_ZERO_RESET_OUT,
  output logic                             TWO_WIRE_UNIT_ONE_RESET_OUT,
  output logic                             SYNC_SERIAL_ZERO_RESET_OUT,
  output logic                             SYNC_SERIAL_ONE_RESET_OUT,
  output logic                             ASYNC_SERIAL_ZERO_RESET_OUT,
  output logic                             ASYNC_SERIAL_ONE_RESET_OUT,
  output logic                             ASYNC_SERIAL_TWO_RESET_OUT
);
  import psrc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0]       ctrl_a_ff;
  logic [31:0]       ctrl_b_ff;
  logic              aw_held_ff;
  logic              w_held_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [31:0]       w_data_ff;
  logic [3:0]        w_strb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  logic [31:0]       strb_bits;
  logic              wr_commit;
  logic              hit_a;
  logic              hit_b;
  logic              rd_take;
  logic [31:0]       nxt_ctrl_a;
  logic [31:0]       nxt_ctrl_b;

  // ----------------------------------------------------------------
  // write channel acceptance
  // ----------------------------------------------------------------
  // each channel holds one item; a second one waits until the first is committed
  assign S_AXI_AWREADY_OUT = !aw_held_ff;
  assign S_AXI_WREADY_OUT  = !w_held_ff;
  assign wr_commit         = aw_held_ff && w_held_ff && !bvalid_ff;
  assign hit_a             = (aw_addr_ff[ADDR_W-1:2] == OFS_CTRL_A[ADDR_W-1:2]);
  assign hit_b             = (aw_addr_ff[ADDR_W-1:2] == OFS_CTRL_B[ADDR_W-1:2]);

  // address side, taken in either order with data
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
    end
    else if (S_AXI_AWVALID_IN && !aw_held_ff)
    begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= S_AXI_AWADDR_IN;
    end
    else if (wr_commit)
    begin
      aw_held_ff <= 1'b0;
    end
  end

  // data side
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      w_held_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end
    else if (S_AXI_WVALID_IN && !w_held_ff)
    begin
      w_held_ff <= 1'b1;
      w_data_ff <= S_AXI_WDATA_IN;
      w_strb_ff <= S_AXI_WSTRB_IN;
    end
    else if (wr_commit)
    begin
      w_held_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // byte strobes widened to bit enables
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++)
    begin : g_strb
      assign strb_bits[gi] = w_strb_ff[gi/8];
    end
  endgenerate

  // ----------------------------------------------------------------
  // next register values
  // ----------------------------------------------------------------
  // absent units and reserved bits are protected by the same mask term
  always_comb
  begin
    nxt_ctrl_a = ctrl_a_ff;
    nxt_ctrl_b = ctrl_b_ff;
    if (wr_commit && hit_a)
    begin
      nxt_ctrl_a = (ctrl_a_ff & ~(IMPL_MASK_A & CAPABILITY_MASK_A_IN & strb_bits))
                 | (w_data_ff & IMPL_MASK_A & CAPABILITY_MASK_A_IN & strb_bits);
    end
    if (wr_commit && hit_b)
    begin
      nxt_ctrl_b = (ctrl_b_ff & ~(IMPL_MASK_B & CAPABILITY_MASK_B_IN & strb_bits))
                 | (w_data_ff & IMPL_MASK_B & CAPABILITY_MASK_B_IN & strb_bits);
    end
  end

  // control registers, cleared by system reset
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      ctrl_a_ff <= CTRL_RESET;
      ctrl_b_ff <= CTRL_RESET;
    end
    else
    begin
      ctrl_a_ff <= nxt_ctrl_a;
      ctrl_b_ff <= nxt_ctrl_b;
    end
  end

  // ----------------------------------------------------------------
  // write response
  // ----------------------------------------------------------------
  // an unmapped address still completes, but with an error answer
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end
    else if (wr_commit)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (hit_a || hit_b) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_BREADY_IN)
    begin
      bvalid_ff <= 1'b0;
    end
  end

  assign S_AXI_BVALID_OUT = bvalid_ff;
  assign S_AXI_BRESP_OUT  = bresp_ff;

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign S_AXI_ARREADY_OUT = !rvalid_ff;
  assign rd_take           = S_AXI_ARVALID_IN && !rvalid_ff;

  // reserved positions are never stored, so they read back as zero
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_ff <= 1'b1;
      if (S_AXI_ARADDR_IN[ADDR_W-1:2] == OFS_CTRL_A[ADDR_W-1:2])
      begin
        rdata_ff <= ctrl_a_ff & IMPL_MASK_A;
        rresp_ff <= RESP_OKAY;
      end
      else if (S_AXI_ARADDR_IN[ADDR_W-1:2] == OFS_CTRL_B[ADDR_W-1:2])
      begin
        rdata_ff <= ctrl_b_ff & IMPL_MASK_B;
        rresp_ff <= RESP_OKAY;
      end
      else
      begin
        rdata_ff <= 32'h0000_0000;
        rresp_ff <= RESP_SLVERR;
      end
    end
    else if (S_AXI_RREADY_IN)
    begin
      rvalid_ff <= 1'b0;
    end
  end

  assign S_AXI_RVALID_OUT = rvalid_ff;
  assign S_AXI_RDATA_OUT  = rdata_ff;
  assign S_AXI_RRESP_OUT  = rresp_ff;

  // ----------------------------------------------------------------
  // unit reset outputs
  // ----------------------------------------------------------------
  // straight from the flops, so no decode glitch reaches a unit reset
  assign CAN_UNIT_ZERO_RESET_OUT        = ctrl_a_ff[BIT_CAN_UNIT_ZERO_RESET];
  assign POWER_DOWN_UNIT_RESET_OUT      = ctrl_a_ff[BIT_PWRDN];
  assign WATCHDOG_UNIT_RESET_OUT        = ctrl_a_ff[BIT_WDOG];
  assign COMPARATOR_UNIT_ONE_RESET_OUT  = ctrl_b_ff[BIT_CMP1];
  assign COMPARATOR_UNIT_ZERO_RESET_OUT = ctrl_b_ff[BIT_CMP0];
  assign GP_COUNTER_THREE_RESET_OUT     = ctrl_b_ff[BIT_GPC3];
  assign GP_COUNTER_TWO_RESET_OUT       = ctrl_b_ff[BIT_GPC2];
  assign GP_COUNTER_ONE_RESET_OUT       = ctrl_b_ff[BIT_GPC1];
  assign GP_COUNTER_ZERO_RESET_OUT      = ctrl_b_ff[BIT_GPC0];
  assign TWO_WIRE_UNIT_ONE_RESET_OUT    = ctrl_b_ff[BIT_TW1];
  assign TWO_WIRE_UNIT_ZERO_RESET_OUT   = ctrl_b_ff[BIT_TW0];
  assign SYNC_SERIAL_ONE_RESET_OUT      = ctrl_b_ff[BIT_SS1];
  assign SYNC_SERIAL_ZERO_RESET_OUT     = ctrl_b_ff[BIT_SS0];
  assign ASYNC_SERIAL_TWO_RESET_OUT     = ctrl_b_ff[BIT_AS2];
  assign ASYNC_SERIAL_ONE_RESET_OUT     = ctrl_b_ff[BIT_AS1];
  assign ASYNC_SERIAL_ZERO_RESET_OUT    = ctrl_b_ff[BIT_AS0];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  // a full-strobe write to one register with its unit present
  sequence s_full_wr_a(int b);
    wr_commit && hit_a && (w_strb_ff == 4'hf) && CAPABILITY_MASK_A_IN[b];
  endsequence

  sequence s_full_wr_b(int b);
    wr_commit && hit_b && (w_strb_ff == 4'hf) && CAPABILITY_MASK_B_IN[b];
  endsequence

  a_mask_a_write: assert property (
    wr_commit |=> ((ctrl_a_ff ^ $past(ctrl_a_ff)) & ~$past(CAPABILITY_MASK_A_IN)) == 32'h0)
    else $error("absent unit bit changed in control a");

  a_mask_b_write: assert property (
    wr_commit |=> ((ctrl_b_ff ^ $past(ctrl_b_ff)) & ~$past(CAPABILITY_MASK_B_IN)) == 32'h0)
    else $error("absent unit bit changed in control b");

  a_can_reset_set: assert property (
    s_full_wr_a(BIT_CAN_UNIT_ZERO_RESET) |=> CAN_UNIT_ZERO_RESET_OUT == $past(w_data_ff[BIT_CAN_UNIT_ZERO_RESET]))
    else $error("can unit reset does not follow write");

  a_pwrdn_reset_set: assert property (
    s_full_wr_a(BIT_PWRDN) |=> POWER_DOWN_UNIT_RESET_OUT == $past(w_data_ff[BIT_PWRDN]))
    else $error("power-down unit reset does not follow write");

  a_wdog_reset_set: assert property (
    s_full_wr_a(BIT_WDOG) |=> WATCHDOG_UNIT_RESET_OUT == $past(w_data_ff[BIT_WDOG]))
    else $error("watchdog unit reset does not follow write");

  a_cmp_reset_set: assert property (
    s_full_wr_b(BIT_CMP1) |=> COMPARATOR_UNIT_ONE_RESET_OUT == $past(w_data_ff[BIT_CMP1]))
    else $error("comparator one reset does not follow write");

  a_gpc_reset_set: assert property (
    s_full_wr_b(BIT_GPC3) |=> GP_COUNTER_THREE_RESET_OUT == $past(w_data_ff[BIT_GPC3]))
    else $error("counter three reset does not follow write");

  a_tw1_reset_set: assert property (
    s_full_wr_b(BIT_TW1) |=> TWO_WIRE_UNIT_ONE_RESET_OUT == $past(w_data_ff[BIT_TW1]))
    else $error("two-wire one reset does not follow write");

  a_tw0_reset_set: assert property (
    s_full_wr_b(BIT_TW0) |=> TWO_WIRE_UNIT_ZERO_RESET_OUT == $past(w_data_ff[BIT_TW0]))
    else $error("two-wire zero reset does not follow write");

  a_ss_reset_set: assert property (
    s_full_wr_b(BIT_SS0) |=> SYNC_SERIAL_ZERO_RESET_OUT == $past(w_data_ff[BIT_SS0]))
    else $error("sync serial zero reset does not follow write");

  a_as_reset_set: assert property (
    s_full_wr_b(BIT_AS2) |=> ASYNC_SERIAL_TWO_RESET_OUT == $past(w_data_ff[BIT_AS2]))
    else $error("async serial two reset does not follow write");

  a_reset_zero_state: assert property (
    !$past(RESET_N_IN) |-> (ctrl_a_ff == CTRL_RESET) && (ctrl_b_ff == CTRL_RESET))
    else $error("control registers not zero after reset");

  a_reserved_read_zero: assert property (
    rd_take && (S_AXI_ARADDR_IN[ADDR_W-1:2] == OFS_CTRL_B[ADDR_W-1:2])
    |=> S_AXI_RVALID_OUT && ((S_AXI_RDATA_OUT & ~IMPL_MASK_B) == 32'h0))
    else $error("reserved bits read non-zero");

  a_release_next_edge: assert property (
    s_full_wr_a(BIT_WDOG) ##0 !w_data_ff[BIT_WDOG] |=> !WATCHDOG_UNIT_RESET_OUT [*2])
    else $error("watchdog reset not released after clearing");

endmodule

// ### dv/peripheral_soft_reset_control_bench.sv
// self-checking bench for the soft reset control registers
`timescale 1ns/1ps
module peripheral_soft_reset_control_bench;
  import psrc_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic        clk_in;
  logic        reset_n_in;
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [31:0] cap_a;
  logic [31:0] cap_b;
  logic [15:0] rst;
  logic [31:0] out_a;
  logic [31:0] out_b;
  int          miscompares;
  int          checks_done;

  // unit resets gathered back into register bit positions
  assign out_a = {7'h0, rst[0], 17'h0, rst[1], 2'h0, rst[2], 3'h0};
  assign out_b = {6'h0, rst[4], rst[3], 4'h0, rst[8], rst[7], rst[6], rst[5], 1'b0, rst[10],
                  1'b0, rst[9], 6'h0, rst[12], rst[11], 1'b0, rst[15], rst[14], rst[13]};

  psrc_top psrc_top_i (
    .CLK_IN(clk_in), .RESET_N_IN(reset_n_in),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
    .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
    .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
    .CAPABILITY_MASK_A_IN(cap_a), .CAPABILITY_MASK_B_IN(cap_b),
    .CAN_UNIT_ZERO_RESET_OUT(rst[0]), .POWER_DOWN_UNIT_RESET_OUT(rst[1]),
    .WATCHDOG_UNIT_RESET_OUT(rst[2]), .COMPARATOR_UNIT_ZERO_RESET_OUT(rst[3]),
    .COMPARATOR_UNIT_ONE_RESET_OUT(rst[4]), .GP_COUNTER_ZERO_RESET_OUT(rst[5]),
    .GP_COUNTER_ONE_RESET_OUT(rst[6]), .GP_COUNTER_TWO_RESET_OUT(rst[7]),
    .GP_COUNTER_THREE_RESET_OUT(rst[8]), .TWO_WIRE_UNIT_ZERO_RESET_OUT(rst[9]),
    .TWO_WIRE_UNIT_ONE_RESET_OUT(rst[10]), .SYNC_SERIAL_ZERO_RESET_OUT(rst[11]),
    .SYNC_SERIAL_ONE_RESET_OUT(rst[12]), .ASYNC_SERIAL_ZERO_RESET_OUT(rst[13]),
    .ASYNC_SERIAL_ONE_RESET_OUT(rst[14]), .ASYNC_SERIAL_TWO_RESET_OUT(rst[15])
  );

  // 200 MHz system clock
  always #2.5 clk_in = ~clk_in;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  // ready is sampled mid-cycle, so the decision at the edge never races the design
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] exp_resp);
    logic aw_done, w_done, hit_aw, hit_w, hit_b;
    logic [1:0] resp;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge clk_in);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(negedge clk_in);
      hit_aw = awvalid && awready;
      hit_w  = wvalid && wready;
      @(posedge clk_in);
      if (hit_aw)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (hit_w)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do
    begin
      @(negedge clk_in);
      hit_b = bvalid;
      resp  = bresp;
      @(posedge clk_in);
    end while (hit_b !== 1'b1);
    bready <= 1'b0;
    check({30'h0, resp}, {30'h0, exp_resp}, "write response");
  endtask

  task automatic axi_read(input logic [11:0] a, input logic [31:0] exp,
                          input logic [1:0] exp_resp);
    logic hit;
    logic [31:0] d;
    logic [1:0] resp;
    @(posedge clk_in);
    araddr  <= a;
    arvalid <= 1'b1;
    do
    begin
      @(negedge clk_in);
      hit = arvalid && arready;
      @(posedge clk_in);
    end while (hit !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do
    begin
      @(negedge clk_in);
      hit  = rvalid;
      d    = rdata;
      resp = rresp;
      @(posedge clk_in);
    end while (hit !== 1'b1);
    rready <= 1'b0;
    check(d, exp, "read data");
    check({30'h0, resp}, {30'h0, exp_resp}, "read response");
  endtask

  task automatic print_verdict;
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    axi_read(OFS_CTRL_A, 32'h0, RESP_OKAY);
    axi_read(OFS_CTRL_B, 32'h0, RESP_OKAY);
    check(out_a | out_b, 32'h0, "unit resets after reset");
  endtask

  // one-hot walk: each bit lands on its own unit and the previous one is released
  task automatic t_bit_walk;
    logic [31:0] e;
    cap_a <= 32'hffff_ffff;
    cap_b <= 32'hffff_ffff;
    for (int i = 0; i < 32; i++)
    begin
      e = (32'h1 << i) & IMPL_MASK_A;
      axi_write(OFS_CTRL_A, 32'h1 << i, 4'hf, RESP_OKAY);
      check(out_a, e, "control a units");
      axi_read(OFS_CTRL_A, e, RESP_OKAY);
      e = (32'h1 << i) & IMPL_MASK_B;
      axi_write(OFS_CTRL_B, 32'h1 << i, 4'hf, RESP_OKAY);
      check(out_b, e, "control b units");
      axi_read(OFS_CTRL_B, e, RESP_OKAY);
    end
  endtask

  task automatic t_cap_mask;
    axi_write(OFS_CTRL_A, 32'hffff_ffff, 4'hf, RESP_OKAY);
    axi_write(OFS_CTRL_B, 32'hffff_ffff, 4'hf, RESP_OKAY);
    cap_a <= 32'h0000_0008;
    cap_b <= 32'h0001_0001;
    axi_write(OFS_CTRL_A, 32'h0, 4'hf, RESP_OKAY);
    axi_write(OFS_CTRL_B, 32'h0, 4'hf, RESP_OKAY);
    axi_read(OFS_CTRL_A, IMPL_MASK_A & ~32'h8, RESP_OKAY);
    axi_read(OFS_CTRL_B, IMPL_MASK_B & ~32'h0001_0001, RESP_OKAY);
    cap_a <= 32'hffff_ffff;
    cap_b <= 32'hffff_ffff;
    axi_write(OFS_CTRL_A, 32'h0, 4'hf, RESP_OKAY);
    axi_write(OFS_CTRL_B, 32'h0, 4'hf, RESP_OKAY);
    cap_a <= ~IMPL_MASK_A;
    cap_b <= ~IMPL_MASK_B;
    axi_write(OFS_CTRL_A, 32'hffff_ffff, 4'hf, RESP_OKAY);
    axi_write(OFS_CTRL_B, 32'hffff_ffff, 4'hf, RESP_OKAY);
    check(out_a, 32'h0, "absent units a");
    check(out_b, 32'h0, "absent units b");
    cap_a <= 32'hffff_ffff;
    cap_b <= 32'hffff_ffff;
  endtask

  // a partial strobe changes only its byte lane; unmapped slots must leave the registers alone
  task automatic t_strobe_unmapped;
    axi_write(OFS_CTRL_B, 32'hffff_ffff, 4'h1, RESP_OKAY);
    check(out_b, IMPL_MASK_B & 32'hff, "strobe low byte");
    axi_write(12'h048, 32'hffff_ffff, 4'hf, RESP_SLVERR);
    axi_write(12'h03c, 32'hffff_ffff, 4'hf, RESP_SLVERR);
    check(out_a, 32'h0, "unmapped keeps a");
    axi_read(12'h048, 32'h0, RESP_SLVERR);
    axi_read(OFS_CTRL_B, IMPL_MASK_B & 32'hff, RESP_OKAY);
  endtask

  task automatic t_mid_reset;
    axi_write(OFS_CTRL_A, 32'hffff_ffff, 4'hf, RESP_OKAY);
    axi_write(OFS_CTRL_B, 32'hffff_ffff, 4'hf, RESP_OKAY);
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_reset_values();
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk_in      = 1'b0;
    reset_n_in  = 1'b0;
    miscompares = 0;
    checks_done = 0;
    awaddr      = '0;
    awvalid     = 1'b0;
    wdata       = '0;
    wstrb       = '0;
    wvalid      = 1'b0;
    bready      = 1'b0;
    araddr      = '0;
    arvalid     = 1'b0;
    rready      = 1'b0;
    cap_a       = '0;
    cap_b       = '0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_reset_values();
    t_bit_walk();
    t_cap_mask();
    t_strobe_unmapped();
    t_mid_reset();
    print_verdict();
  end

  // the whole run needs well under 2000 cycles
  initial
  begin
    #50000;
    miscompares++;
    print_verdict();
  end
endmodule
